// File: hdl/pcs_pkg.sv
// Purpose: Shared constants and carrier types for the clock synthesizer block
// Assumes: One core clock; configuration arrives from the serial register front end
// Notes:   Every field position and configuration register reset value used by the design lives here
`default_nettype none
package pcs_pkg;
	// Register offsets
	localparam logic [7:0] PCS_OFS_PLL_ADC = 8'h04;
	localparam logic [7:0] PCS_OFS_AUX     = 8'h06;
	// Register reset values
	localparam logic [7:0] PCS_RST_PLL_ADC = 8'h00;
	localparam logic [7:0] PCS_RST_AUX     = 8'h00;
	// Field positions in pll_and_adc_clock_config
	localparam int PCS_M_LSB   = 0;
	localparam int PCS_N_LSB   = 2;
	localparam int PCS_SEL_BIT = 4;
	// Field positions in aux_clock_output_config
	localparam int PCS_P_DIS_BIT = 0;
	localparam int PCS_P_INV_BIT = 1;
	localparam int PCS_R_LSB     = 2;
	localparam int PCS_Q_DIS_BIT = 4;
	localparam int PCS_Q_INV_BIT = 5;
	localparam int PCS_L_LSB     = 6;
	// Receive path latency in sampling-clock periods
	localparam int PCS_RX_LAT = 10;
	localparam int PCS_RX_W   = 12;
	// Width in bits of the reference period counter, which counts core cycles
	localparam int PCS_CNT_W  = 8;
	// Largest legal exponent for the N and L divide fields
	localparam logic [1:0] PCS_EXP_MAX2 = 2'h2;

	typedef struct packed {
		logic       adc_from_vco;
		logic [1:0] n_exp;
		logic [1:0] m_exp;
	} pcs_pll_cfg_s;

	typedef struct packed {
		logic [1:0] l_exp;
		logic       q_inv;
		logic       q_dis;
		logic [1:0] r_exp;
		logic       p_inv;
		logic       p_dis;
	} pcs_aux_cfg_s;
endpackage
`default_nettype wire

// File: hdl/pcs_delay_line.sv
// Purpose: Fixed pipeline delay for receive samples, advanced on sampling enables
// Assumes: shift_en is a one-cycle pulse per sampling period
// Notes:   Read data always comes from a register
`default_nettype none
module pcs_delay_line #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 10
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             shift_en,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] mem      [DEPTH];
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic [WIDTH-1:0] next_dout;

	// Shift one stage per sampling period; output register adds the last stage
	always_comb begin
		next_dout = dout;
		for (int i = 0; i < DEPTH; i++) begin
			next_mem[i] = mem[i];
		end
		if (shift_en) begin
			next_dout  = mem[DEPTH-1];
			next_mem[0] = din;
			for (int i = 1; i < DEPTH; i++) begin
				next_mem[i] = mem[i-1];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			dout <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else begin
			dout <= next_dout;
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= next_mem[i];
			end
		end
	end
endmodule
`default_nettype wire

// File: hdl/pcs_clock_synth.sv
// Purpose: Clock synthesizer: PLL multiplier model, ADC clock select, two aux clock outputs
// Assumes: core_clk is far faster than the reference; reference_input is asynchronous
// Notes:   Clocks are produced as levels and one-cycle enables on core_clk
`default_nettype none
module pcs_clock_synth (
	input  wire logic                         core_clk,
	input  wire logic                         srst,
	input  wire logic                         reference_input,
	input  wire logic                         reg_wr,
	input  wire logic [7:0]                   reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	output logic      [7:0]                   reg_rdata,
	input  wire logic                         full_duplex,
	input  wire logic [1:0]                   interp_exp,
	input  wire logic [pcs_pkg::PCS_RX_W-1:0] rx_gain_sample,
	output logic      [pcs_pkg::PCS_RX_W-1:0] rx_data,
	output logic                              adc_clk,
	output logic                              adc_sample_en,
	output logic                              dac_update_en,
	output logic                              tx_word_en,
	output logic                              receive_word_clock,
	output logic                              primary_clock_output,
	output logic                              reference_clock_output
);
	import pcs_pkg::*;

	pcs_pll_cfg_s pll_cfg, next_pll_cfg;
	pcs_aux_cfg_s aux_cfg, next_aux_cfg;

	// Configuration registers written by the serial front end
	always_comb begin
		next_pll_cfg = pll_cfg;
		next_aux_cfg = aux_cfg;
		if (reg_wr && reg_addr == PCS_OFS_PLL_ADC) begin
			next_pll_cfg.m_exp        = reg_wdata[PCS_M_LSB +: 2];
			next_pll_cfg.n_exp        = reg_wdata[PCS_N_LSB +: 2];
			next_pll_cfg.adc_from_vco = reg_wdata[PCS_SEL_BIT];
		end
		if (reg_wr && reg_addr == PCS_OFS_AUX) begin
			next_aux_cfg.p_dis = reg_wdata[PCS_P_DIS_BIT];
			next_aux_cfg.p_inv = reg_wdata[PCS_P_INV_BIT];
			next_aux_cfg.r_exp = reg_wdata[PCS_R_LSB +: 2];
			next_aux_cfg.q_dis = reg_wdata[PCS_Q_DIS_BIT];
			next_aux_cfg.q_inv = reg_wdata[PCS_Q_INV_BIT];
			next_aux_cfg.l_exp = reg_wdata[PCS_L_LSB +: 2];
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pll_cfg <= pcs_pll_cfg_s'(PCS_RST_PLL_ADC[4:0]);
			aux_cfg <= pcs_aux_cfg_s'(PCS_RST_AUX);
		end else begin
			pll_cfg <= next_pll_cfg;
			aux_cfg <= next_aux_cfg;
		end
	end

	// Read back; unmapped offsets read as zero
	always_comb begin
		case (reg_addr)
			PCS_OFS_PLL_ADC: reg_rdata = {3'h0, pll_cfg};
			PCS_OFS_AUX:     reg_rdata = aux_cfg;
			default:         reg_rdata = 8'h00;
		endcase
	end

	// Clamp a two-bit exponent whose top code is not legal
	function automatic logic [1:0] pcs_clamp2(input logic [1:0] e);
		return (e > PCS_EXP_MAX2) ? PCS_EXP_MAX2 : e;
	endfunction

	// Ones in the chain bits below a two-bit exponent
	function automatic logic [2:0] pcs_low_mask(input logic [1:0] e);
		return (3'h1 << e) - 3'h1;
	endfunction

	// Pick a level from the VCO or one tap of its divider chain
	function automatic logic pcs_tap(input logic lvl, input logic [2:0] ch, input logic [1:0] e);
		case (e)
			2'h0:    return lvl;
			2'h1:    return ch[0];
			2'h2:    return ch[1];
			default: return ch[2];
		endcase
	endfunction

	// Clock generation state. It is cleared only by the first reset after power up,
	// so the aux outputs keep running through every later reset.
	logic                 clk_alive = 1'b0;
	logic                 ref_meta, ref_s, ref_d;
	logic [PCS_CNT_W-1:0] ref_cnt, ref_per, vco_ph;
	logic [2:0]           div_chain;
	logic [1:0]           ref_div;
	logic [PCS_CNT_W-1:0] next_ref_cnt, next_ref_per, next_vco_ph, vco_per;
	logic [2:0]           next_div_chain;
	logic [1:0]           next_ref_div;
	logic                 ref_rise, vco_tick, vco_lvl, clk_init;

	assign ref_rise = ref_s && !ref_d;
	assign clk_init = srst && !clk_alive;

	// The VCO period follows the measured reference period shifted by the multiply exponent
	always_comb begin
		vco_per = ref_per >> pll_cfg.m_exp;
		if (vco_per == '0) begin
			vco_per = PCS_CNT_W'(1);
		end
		vco_tick       = (vco_ph == vco_per - PCS_CNT_W'(1));
		vco_lvl        = (vco_ph < (vco_per >> 1));
		next_ref_cnt   = ref_cnt + PCS_CNT_W'(1);
		next_ref_per   = ref_per;
		next_vco_ph    = vco_tick ? '0 : vco_ph + PCS_CNT_W'(1);
		next_div_chain = vco_tick ? div_chain + 3'h1 : div_chain;
		next_ref_div   = ref_div;
		if (ref_rise) begin
			next_ref_cnt   = '0;
			next_ref_per   = ref_cnt + PCS_CNT_W'(1);
			next_vco_ph    = '0;
			// Clear only the bits below the multiply exponent; the upper bits divide the
			// VCO below the reference rate and must keep counting across reference edges
			next_div_chain = next_div_chain & ~pcs_low_mask(pll_cfg.m_exp);
			next_ref_div   = ref_div + 2'h1;
		end
	end

	// Reference synchroniser and divider chain; not held by later resets
	always_ff @(posedge core_clk) begin
		clk_alive <= clk_alive | srst;
		ref_meta  <= reference_input;
		ref_s     <= ref_meta;
		ref_d     <= ref_s;
		if (clk_init) begin
			ref_cnt   <= '0;
			ref_per   <= PCS_CNT_W'(1);
			vco_ph    <= '0;
			div_chain <= '0;
			ref_div   <= '0;
		end else begin
			ref_cnt   <= next_ref_cnt;
			ref_per   <= next_ref_per;
			vco_ph    <= next_vco_ph;
			div_chain <= next_div_chain;
			ref_div   <= next_ref_div;
		end
	end

	// Clock selection and output stage
	logic adc_lvl, adc_d, p_raw, q_raw;
	always_comb begin
		adc_lvl = pll_cfg.adc_from_vco
			? pcs_tap(vco_lvl, div_chain, pcs_clamp2(pll_cfg.n_exp))
			: ref_s;
		p_raw = pcs_tap(vco_lvl, div_chain, aux_cfg.r_exp);
		case (pcs_clamp2(aux_cfg.l_exp))
			2'h0:    q_raw = ref_s;
			2'h1:    q_raw = ref_div[0];
			default: q_raw = ref_div[1];
		endcase
	end

	always_ff @(posedge core_clk) begin
		adc_d <= adc_lvl;
	end

	assign adc_clk       = adc_lvl;
	assign adc_sample_en = adc_lvl && !adc_d;
	assign dac_update_en = vco_tick;
	// Word strobe: one converter update in every 2^interp_exp, locked to the chain
	assign tx_word_en = vco_tick
		&& (div_chain & pcs_low_mask(interp_exp)) == pcs_low_mask(interp_exp);
	// Full duplex moves nibbles, so its word clock is the chain one tap faster than the word rate, or the VCO level itself when interp_exp is 0
	assign receive_word_clock = full_duplex
		? pcs_tap(vco_lvl, div_chain, (interp_exp == 2'h0) ? 2'h0 : interp_exp - 2'h1)
		: adc_lvl;
	assign primary_clock_output   = !aux_cfg.p_dis && (p_raw ^ aux_cfg.p_inv);
	assign reference_clock_output = !aux_cfg.q_dis && (q_raw ^ aux_cfg.q_inv);

	// Receive pipeline: ten sampling periods, plus half a period in full duplex
	logic [PCS_RX_W-1:0] rx_pipe, rx_half, next_rx_half;
	logic                adc_fall;
	assign adc_fall = !adc_lvl && adc_d;

	pcs_delay_line #(
		.WIDTH (PCS_RX_W),
		.DEPTH (PCS_RX_LAT)
	) u_rx_delay (
		.core_clk (core_clk),
		.srst     (srst),
		.shift_en (adc_sample_en),
		.din      (rx_gain_sample),
		.dout     (rx_pipe)
	);

	always_comb begin
		next_rx_half = adc_fall ? rx_pipe : rx_half;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rx_half <= '0;
		end else begin
			rx_half <= next_rx_half;
		end
	end

	// Both sources are registers; the mux only picks the duplex mode
	assign rx_data = full_duplex ? rx_half : rx_pipe;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_rx_full_hold: assert property (full_duplex && !adc_fall |=> $stable(rx_half))
		else $error("Full duplex receive data moved off the falling edge");
	a_rx_full_take: assert property (adc_fall |=> rx_half == $past(rx_pipe))
		else $error("Full duplex receive data missed the half-period stage");
	a_chain_align: assert property (ref_rise
		|=> (div_chain & pcs_low_mask($past(pll_cfg.m_exp))) == 3'h0 && vco_ph == '0)
		else $error("Divider chain not aligned to reference edge");
	a_adc_src_ref: assert property (!pll_cfg.adc_from_vco |-> adc_clk == ref_s)
		else $error("ADC clock not the buffered reference");
	a_adc_src_vco: assert property (pll_cfg.adc_from_vco && pll_cfg.n_exp == 2'h1
		|-> adc_clk == div_chain[0])
		else $error("ADC clock not VCO divided by two");
	a_prim_div: assert property (aux_cfg.r_exp == 2'h2 && !aux_cfg.p_dis && !aux_cfg.p_inv
		|-> primary_clock_output == div_chain[1])
		else $error("Primary output not VCO divided by four");
	a_prim_disable: assert property (aux_cfg.p_dis |-> !primary_clock_output)
		else $error("Primary output active while disabled");
	a_ref_invert: assert property (aux_cfg.l_exp == 2'h0 && !aux_cfg.q_dis && aux_cfg.q_inv
		|-> reference_clock_output == !ref_s)
		else $error("Reference output not the inverted reference");
	a_ref_div_step: assert property (disable iff (1'b0)
		clk_alive && ref_rise |=> ref_div == $past(ref_div) + 2'h1)
		else $error("Reference divider stalled");
	a_dac_word: assert property (tx_word_en |-> dac_update_en)
		else $error("Word strobe without a converter update");
	a_mult_period: assert property (ref_rise |=> ##1 vco_per == (ref_per >> pll_cfg.m_exp)
		|| vco_per == PCS_CNT_W'(1) || $changed(pll_cfg))
		else $error("VCO period does not follow the multiply exponent");
	a_receive_word_clock_full: assert property (full_duplex && interp_exp == 2'h1
		|-> receive_word_clock == vco_lvl)
		else $error("Full duplex word clock not at twice the word rate");

	c_vco_adc: cover property (pll_cfg.adc_from_vco && adc_sample_en);
	c_full_rx: cover property (full_duplex && adc_fall && rx_pipe != '0);
	c_reset_toggle: cover property (disable iff (1'b0) srst && clk_alive && ref_rise);
endmodule
`default_nettype wire

// File: dv/pcs_backend_model.sv
// Purpose: Back-end model that consumes the generated clocks and feeds receive samples
// Assumes: Every clock is far slower than core_clk, so sampling on core_clk is exact
// Notes:   Keeps the last rise-to-rise gap and the last high time of each clock
`default_nettype none
module pcs_backend_model (
	input  wire logic        core_clk,
	input  wire logic [5:0]  clk_vec,
	input  wire logic        adc_sample_en,
	output logic      [11:0] rx_gain_sample,
	output logic      [7:0]  gap [6],
	output logic      [7:0]  hi [6]
);
	logic [5:0] prev;
	logic [7:0] run [6];
	logic [7:0] hcnt [6];

	// Known start values, so the first gap is junk but never unknown
	initial begin
		prev = 6'h00;
		rx_gain_sample = 12'h000;
		for (int i = 0; i < 6; i++) begin
			run[i] = 8'h00;
			hcnt[i] = 8'h00;
			gap[i] = 8'h00;
			hi[i] = 8'h00;
		end
	end

	// One new word per sampling period, tagged by its sequence number
	always @(posedge core_clk) begin
		if (adc_sample_en) begin
			rx_gain_sample <= rx_gain_sample + 12'h001;
		end
	end

	// Edge bookkeeping; a clock that stops simply freezes its last figures
	// The primary output is the one a system would distribute, index 1
	always @(posedge core_clk) begin
		prev <= clk_vec;
		for (int i = 0; i < 6; i++) begin
			run[i] <= (clk_vec[i] && !prev[i]) ? 8'h01 : run[i] + 8'h01;
			hcnt[i] <= clk_vec[i] ? hcnt[i] + 8'h01 : 8'h00;
			if (clk_vec[i] && !prev[i]) gap[i] <= run[i];
			if (!clk_vec[i] && prev[i]) hi[i] <= hcnt[i];
		end
	end
endmodule
`default_nettype wire

// File: dv/tb.sv
// Purpose: Self-checking bench for the clock synthesizer
// Assumes: Reference period 16 core cycles, high 6, so duty copies are visible
// Notes:   Clock index 0 dac, 1 primary, 2 reference out, 3 adc, 4 tx word, 5 rx word
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic        reference_input = 1'b0;
	logic        reg_wr = 1'b0;
	logic        full_duplex = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [1:0]  interp_exp = 2'h0;
	logic [3:0]  ref_cnt = 4'h0;
	logic [7:0]  reg_rdata;
	logic [11:0] rx_gain_sample;
	logic [11:0] rx_data;
	logic        adc_clk, adc_sample_en, dac_update_en, tx_word_en, receive_word_clock;
	logic        primary_clock_output, reference_clock_output;
	logic [7:0]  gap [6];
	logic [7:0]  hi [6];
	int          n_mismatch = 0;
	int          tests_run = 0;

	pcs_clock_synth pcs_clock_synth_i (.core_clk(core_clk), .srst(srst),
		.reference_input(reference_input), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .full_duplex(full_duplex),
		.interp_exp(interp_exp), .rx_gain_sample(rx_gain_sample), .rx_data(rx_data),
		.adc_clk(adc_clk), .adc_sample_en(adc_sample_en), .dac_update_en(dac_update_en),
		.tx_word_en(tx_word_en), .receive_word_clock(receive_word_clock),
		.primary_clock_output(primary_clock_output),
		.reference_clock_output(reference_clock_output));
	pcs_backend_model pcs_backend_model_i (.core_clk(core_clk), .adc_sample_en(adc_sample_en),
		.clk_vec({receive_word_clock, tx_word_en, adc_clk, reference_clock_output,
			primary_clock_output, dac_update_en}),
		.rx_gain_sample(rx_gain_sample), .gap(gap), .hi(hi));

	// Core clock, 100 ns period
	always #50 core_clk = ~core_clk;

	// Reference pin, unrelated to any register timing; sixteen core cycles keep the
	// VCO period whole for every multiply exponent
	always @(negedge core_clk) begin
		ref_cnt <= ref_cnt + 4'h1;
		reference_input <= (ref_cnt < 4'h6);
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge core_clk);
		reg_addr = a;
		@(posedge core_clk);
		chk(reg_rdata, e);
	endtask

	// Long enough for the period to be remeasured after a change
	task automatic meas(input int i, input logic [7:0] eg);
		repeat (160) @(negedge core_clk);
		chk(gap[i], eg);
	endtask

	task automatic t_regs();
		rd(8'h04, 8'h00);
		rd(8'h06, 8'h00);
		wr(8'h04, 8'hff);
		rd(8'h04, 8'h1f);
		wr(8'h06, 8'ha5);
		rd(8'h06, 8'ha5);
		wr(8'h05, 8'hff);
		rd(8'h05, 8'h00);
		wr(8'h04, 8'h00);
		wr(8'h06, 8'h00);
	endtask

	task automatic t_pll();
		for (int m = 0; m < 4; m++) begin
			wr(8'h04, m[7:0]);
			meas(0, 8'h10 >> m);
		end
		wr(8'h04, 8'h02);
		for (int r = 0; r < 4; r++) begin
			wr(8'h06, r[7:0] << 2);
			meas(1, 8'h04 << r);
			chk(hi[1], 8'h02 << r);
		end
		for (int k = 0; k < 3; k++) begin
			interp_exp = k[1:0];
			meas(4, 8'h04 << k);
		end
		interp_exp = 2'h0;
	endtask

	task automatic t_adc();
		wr(8'h04, 8'h00);
		meas(3, 8'h10);
		for (int n = 0; n < 3; n++) begin
			wr(8'h04, 8'h12 | (n[7:0] << 2));
			meas(3, 8'h04 << n);
		end
		wr(8'h04, 8'h1e);
		meas(3, 8'h10);
		interp_exp = 2'h2;
		full_duplex = 1'b1;
		wr(8'h04, 8'h1a);
		meas(5, 8'h08);
		full_duplex = 1'b0;
		meas(5, 8'h10);
		interp_exp = 2'h0;
	endtask

	task automatic t_ref();
		int nh;
		nh = 0;
		wr(8'h04, 8'h00);
		wr(8'h06, 8'hc0);
		meas(2, 8'h40);
		for (int l = 0; l < 3; l++) begin
			wr(8'h06, l[7:0] << 6);
			meas(2, 8'h10 << l);
		end
		wr(8'h06, 8'h00);
		meas(2, 8'h10);
		chk(hi[2], 8'h06);
		wr(8'h06, 8'h20);
		meas(2, 8'h10);
		chk(hi[2], 8'h0a);
		wr(8'h06, 8'h11);
		repeat (64) begin
			@(negedge core_clk);
			nh += primary_clock_output + reference_clock_output;
		end
		chk(nh, 0);
		wr(8'h06, 8'h00);
	endtask

	// Outputs must keep running while reset is held
	task automatic t_rst();
		int np;
		int nr;
		np = 0;
		nr = 0;
		srst = 1'b1;
		repeat (64) begin
			@(negedge core_clk);
			np += primary_clock_output;
			nr += reference_clock_output;
		end
		chk(np > 0 && np < 64, 1);
		chk(nr > 0 && nr < 64, 1);
		srst = 1'b0;
	endtask

	task automatic t_rx();
		logic [11:0] p;
		int          k;
		wr(8'h04, 8'h00);
		for (int fd = 0; fd < 2; fd++) begin
			full_duplex = fd[0];
			repeat (200) @(negedge core_clk);
			k = 0;
			while (adc_sample_en !== 1'b1) begin
				@(negedge core_clk);
				k++;
				if (k > 40) begin
					n_mismatch++;
					report_and_stop();
				end
			end
			p = rx_gain_sample; // Word taken at the coming sample edge
			repeat (3) @(negedge core_clk);
			chk(rx_data, p - (fd ? 12'h00b : 12'h00a));
			repeat (11) @(negedge core_clk);
			chk(rx_data, p - 12'h00a);
		end
		full_duplex = 1'b0;
	endtask

	// Main sequence
	initial begin
		repeat (8) @(negedge core_clk);
		srst = 1'b0;
		t_regs();
		t_pll();
		t_adc();
		t_ref();
		t_rst();
		t_rx();
		report_and_stop();
	end
endmodule
`default_nettype wire
